// *** hdl/csrf_core_sfr.v ***
/*
  Core special register bank of a small 8-bit controller, reached over
  an APB slave port. Holds the banked and mirrored core registers, the
  reset-cause logic and the two reset value sets.
  Assumes: power-on reset on rst_b; the other reset causes and the core
  flag updates arrive as same-clock signals from on-chip logic; the
  comparator outputs are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps

module csrf_core_sfr (
  // Clock and power-on reset
  input  wire        clk,
  input  wire        rst_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Non-power-up reset causes, one-cycle pulses
  input  wire        ext_clear_rst,
  input  wire        brownout_rst,
  input  wire        watchdog_rst,
  // Core flag update from the instruction just executed
  input  wire        flag_update,
  input  wire        flag_z_in,
  input  wire        flag_dc_in,
  input  wire        flag_c_in,
  // Comparator status
  input  wire [1:0]  cmp_out,
  input  wire        cmp_change,
  // Register contents toward the core and peripherals
  output reg  [7:0]  timer_count,
  output reg  [7:0]  pc_low,
  output reg  [7:0]  core_flags,
  output reg  [7:0]  indirect_pointer,
  output reg  [4:0]  port_a_pins,
  output reg  [7:0]  port_b_pins,
  output reg  [4:0]  pc_high_latch,
  output reg  [7:0]  irq_control,
  output reg         periph_irq_flags,
  output reg  [3:0]  comparator_control,
  output reg  [7:0]  timer_prescale_config,
  output reg  [4:0]  port_a_direction,
  output reg  [7:0]  port_b_direction,
  output reg         periph_irq_enables,
  output reg  [1:0]  power_reset_cause,
  output reg  [7:0]  voltage_ref_control
);

`include "csrf_regs.vh"

////////////////////////////////////////////////////////////////////////
// Bus decode

  wire       setup_phase;
  wire       wr_done;
  wire       other_rst;
  wire [7:0] file_addr;
  wire [7:0] file_low;
  wire [7:0] wdat;
  wire       out_of_range;

  assign setup_phase  = psel & ~penable;
  // A write outside the file space is refused, so it must not alias
  // onto the register that its low address bits happen to name
  assign wr_done      = psel & penable & pready & pwrite & ~out_of_range;
  assign other_rst    = ext_clear_rst | brownout_rst | watchdog_rst;
  // Bank bit from the flags register forms the top file address bit
  assign file_addr    = {core_flags[`CSRF_FLG_BANK], paddr[8:2]};
  assign file_low     = {1'b0, paddr[8:2]};
  assign wdat         = pwdata[7:0];
  // Words beyond one bank of file space answer with an error
  assign out_of_range = (paddr[31:9] != 23'h00_0000);

  // Mirrored locations match on the low seven bits only
  wire hit_pclo  = wr_done & (file_low == `CSRF_IDX_PCLO0);
  wire hit_flags = wr_done & (file_low == `CSRF_IDX_FLAGS0);
  wire hit_iptr  = wr_done & (file_low == `CSRF_IDX_IPTR0);
  wire hit_pchi  = wr_done & (file_low == `CSRF_IDX_PCHI0);
  wire hit_irqc  = wr_done & (file_low == `CSRF_IDX_IRQC0);

  // Banked locations match the full file address
  wire hit_tcnt  = wr_done & (file_addr == `CSRF_IDX_TMR_CNT);
  wire hit_pa    = wr_done & (file_addr == `CSRF_IDX_PA_PINS);
  wire hit_pb    = wr_done & (file_addr == `CSRF_IDX_PB_PINS);
  wire hit_pirq  = wr_done & (file_addr == `CSRF_IDX_PIRQ_FLG);
  wire hit_cmp   = wr_done & (file_addr == `CSRF_IDX_CMP_CTL);
  wire hit_tcfg  = wr_done & (file_addr == `CSRF_IDX_TMR_CFG);
  wire hit_padir = wr_done & (file_addr == `CSRF_IDX_PA_DIR);
  wire hit_pbdir = wr_done & (file_addr == `CSRF_IDX_PB_DIR);
  wire hit_pien  = wr_done & (file_addr == `CSRF_IDX_PIRQ_EN);
  wire hit_rc    = wr_done & (file_addr == `CSRF_IDX_RST_CAUSE);
  wire hit_vref  = wr_done & (file_addr == `CSRF_IDX_VREF_CTL);

////////////////////////////////////////////////////////////////////////
// Comparator output synchroniser

  reg [1:0] cmp_s1;
  reg [1:0] cmp_s2;
  reg [1:0] cmp_s3;
  reg [1:0] cmp_q;

  // The comparator runs off the analog side, so its outputs pass three
  // flops; a new level is taken only once the last two stages agree,
  // which filters a level caught in mid-change
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmp_s1 <= 2'b00;
      cmp_s2 <= 2'b00;
      cmp_s3 <= 2'b00;
      cmp_q  <= 2'b00;
    end
    else
    begin
      cmp_s1 <= cmp_out;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3)
        cmp_q <= cmp_s3;
    end
  end

////////////////////////////////////////////////////////////////////////
// Read multiplexer

  reg [7:0] next_rdata;

  // Anything not listed, and the indirect port itself, reads as zero
  always @*
  begin
    next_rdata = 8'h00;
    case (file_low)
      `CSRF_IDX_PCLO0:  next_rdata = pc_low;
      `CSRF_IDX_FLAGS0: next_rdata = core_flags;
      `CSRF_IDX_IPTR0:  next_rdata = indirect_pointer;
      `CSRF_IDX_PCHI0:  next_rdata = {3'b000, pc_high_latch};
      `CSRF_IDX_IRQC0:  next_rdata = irq_control;
      default:
      begin
        case (file_addr)
          `CSRF_IDX_TMR_CNT:   next_rdata = timer_count;
          `CSRF_IDX_PA_PINS:   next_rdata = {3'b000, port_a_pins};
          `CSRF_IDX_PB_PINS:   next_rdata = port_b_pins;
          `CSRF_IDX_PIRQ_FLG:
            next_rdata = {1'b0, periph_irq_flags, 6'b00_0000};
          `CSRF_IDX_CMP_CTL:
            next_rdata = {cmp_q, 2'b00, comparator_control};
          `CSRF_IDX_TMR_CFG:   next_rdata = timer_prescale_config;
          `CSRF_IDX_PA_DIR:    next_rdata = {3'b000, port_a_direction};
          `CSRF_IDX_PB_DIR:    next_rdata = port_b_direction;
          `CSRF_IDX_PIRQ_EN:
            next_rdata = {1'b0, periph_irq_enables, 6'b00_0000};
          `CSRF_IDX_RST_CAUSE:
            next_rdata = {6'b00_0000, power_reset_cause};
          `CSRF_IDX_VREF_CTL:
            next_rdata = voltage_ref_control & `CSRF_MSK_VREF;
          default:             next_rdata = 8'h00;
        endcase
      end
    endcase
  end

////////////////////////////////////////////////////////////////////////
// APB handshake

  // Data is captured in the setup cycle so prdata is a clean flop; the
  // price is one fixed wait-free access cycle per transfer, and a read
  // returns the state that stood at the setup edge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_phase;
      if (setup_phase)
      begin
        pslverr <= out_of_range;
        if (!pwrite && !out_of_range)
          prdata <= {24'h00_0000, next_rdata};
        else
          prdata <= 32'h0000_0000;
      end
      else if (pready)
      begin
        pslverr <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////
// Core flags

  // Timeout goes low only on a watchdog reset; other causes set it
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      core_flags <= `CSRF_RST_FLAGS;
    else if (other_rst)
    begin
      core_flags[7:5]          <= 3'b000;
      core_flags[`CSRF_FLG_TMO] <= ~watchdog_rst;
      core_flags[`CSRF_FLG_PWD] <= 1'b1;
    end
    else
    begin
      // Timeout and power-down are never written by software
      if (hit_flags)
        core_flags[7:5] <= wdat[7:5];
      // An instruction that updates the flags wins over its own write
      if (flag_update)
      begin
        core_flags[`CSRF_FLG_Z]   <= flag_z_in;
        core_flags[`CSRF_FLG_DIG] <= flag_dc_in;
        core_flags[`CSRF_FLG_C]   <= flag_c_in;
      end
      else if (hit_flags)
        core_flags[2:0] <= wdat[2:0];
    end
  end

////////////////////////////////////////////////////////////////////////
// Registers that reset alike on every cause

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_low                <= `CSRF_RST_ZERO8;
      pc_high_latch         <= 5'h00;
      timer_prescale_config <= `CSRF_RST_TMR_CFG;
      port_a_direction      <= `CSRF_RST_PA_DIR;
      port_b_direction      <= `CSRF_RST_PB_DIR;
      comparator_control    <= 4'h0;
      voltage_ref_control   <= `CSRF_RST_ZERO8;
      periph_irq_enables    <= 1'b0;
    end
    else if (other_rst)
    begin
      pc_low                <= `CSRF_RST_ZERO8;
      pc_high_latch         <= 5'h00;
      timer_prescale_config <= `CSRF_RST_TMR_CFG;
      port_a_direction      <= `CSRF_RST_PA_DIR;
      port_b_direction      <= `CSRF_RST_PB_DIR;
      comparator_control    <= 4'h0;
      voltage_ref_control   <= `CSRF_RST_ZERO8;
      periph_irq_enables    <= 1'b0;
    end
    else
    begin
      if (hit_pclo)
        pc_low <= wdat;
      if (hit_pchi)
        pc_high_latch <= wdat[4:0];
      if (hit_tcfg)
        timer_prescale_config <= wdat;
      if (hit_padir)
        port_a_direction <= wdat[4:0];
      if (hit_pbdir)
        port_b_direction <= wdat;
      // Comparator outputs are status only; mode bits are written
      if (hit_cmp)
        comparator_control <= wdat[3:0] & `CSRF_MSK_CMP_WR;
      // Bit 4 is not implemented and never stores
      if (hit_vref)
        voltage_ref_control <= wdat & `CSRF_MSK_VREF;
      if (hit_pien)
        periph_irq_enables <= wdat[`CSRF_PIRQ_CMP];
    end
  end

////////////////////////////////////////////////////////////////////////
// Registers that keep their value across non-power-up resets, except port A pins bits 3:0

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_count      <= `CSRF_RST_ZERO8;
      indirect_pointer <= `CSRF_RST_ZERO8;
      port_a_pins      <= 5'h00;
      port_b_pins      <= `CSRF_RST_ZERO8;
    end
    else if (other_rst)
    begin
      // Counter, pointer, port B and port A bit 4 are left as they were
      port_a_pins[3:0] <= 4'h0;
    end
    else
    begin
      if (hit_tcnt)
        timer_count <= wdat;
      if (hit_iptr)
        indirect_pointer <= wdat;
      if (hit_pa)
        port_a_pins <= wdat[4:0];
      if (hit_pb)
        port_b_pins <= wdat;
    end
  end

////////////////////////////////////////////////////////////////////////
// Interrupt control and peripheral flag

  // The change flag in bit 0 survives non-power-up resets untouched
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_control <= `CSRF_RST_ZERO8;
    else if (other_rst)
      irq_control[7:1] <= 7'h00;
    else if (hit_irqc)
      irq_control <= wdat;
  end

  // A comparator event in the cycle of a software clear is kept
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      periph_irq_flags <= 1'b0;
    else if (other_rst)
      periph_irq_flags <= 1'b0;
    else if (cmp_change)
      periph_irq_flags <= 1'b1;
    else if (hit_pirq)
      periph_irq_flags <= wdat[`CSRF_PIRQ_CMP];
  end

////////////////////////////////////////////////////////////////////////
// Reset cause

  // Software sets both bits after start-up so the next reset can be told
  // apart; a brown-out clears its bit, other causes leave it alone
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      power_reset_cause <= 2'b00;
    else if (other_rst)
    begin
      if (brownout_rst)
        power_reset_cause[`CSRF_RC_BRN] <= 1'b0;
    end
    // Only the two cause bits store
    else if (hit_rc)
      power_reset_cause <= wdat[1:0] & `CSRF_MSK_RC;
  end

endmodule // csrf_core_sfr

// *** hdl/csrf_regs.vh ***
/*
  Register indices, field positions and reset values of the core special
  register bank. Each index is a file address; the byte address on the
  bus is four times the low seven bits of it. Definitions only.
*/
`ifndef CSRF_REGS_VH
`define CSRF_REGS_VH

// File indices, bank 0
`define CSRF_IDX_IND0      8'h00
`define CSRF_IDX_TMR_CNT   8'h01
`define CSRF_IDX_PCLO0     8'h02
`define CSRF_IDX_FLAGS0    8'h03
`define CSRF_IDX_IPTR0     8'h04
`define CSRF_IDX_PA_PINS   8'h05
`define CSRF_IDX_PB_PINS   8'h06
`define CSRF_IDX_PCHI0     8'h0a
`define CSRF_IDX_IRQC0     8'h0b
`define CSRF_IDX_PIRQ_FLG  8'h0c
`define CSRF_IDX_CMP_CTL   8'h1f
// File indices, bank 1
`define CSRF_IDX_IND1      8'h80
`define CSRF_IDX_TMR_CFG   8'h81
`define CSRF_IDX_PCLO1     8'h82
`define CSRF_IDX_FLAGS1    8'h83
`define CSRF_IDX_IPTR1     8'h84
`define CSRF_IDX_PA_DIR    8'h85
`define CSRF_IDX_PB_DIR    8'h86
`define CSRF_IDX_PCHI1     8'h8a
`define CSRF_IDX_IRQC1     8'h8b
`define CSRF_IDX_PIRQ_EN   8'h8c
`define CSRF_IDX_RST_CAUSE 8'h8e
`define CSRF_IDX_VREF_CTL  8'h9f

// Core flags fields
`define CSRF_FLG_BANK      5
`define CSRF_FLG_TMO       4
`define CSRF_FLG_PWD       3
`define CSRF_FLG_Z         2
`define CSRF_FLG_DIG       1
`define CSRF_FLG_C         0
// Other single-bit fields
`define CSRF_PIRQ_CMP      6
`define CSRF_RC_PWR        1
`define CSRF_RC_BRN        0

// Power-on values; unknown bits come up as zero
`define CSRF_RST_FLAGS     8'h18
`define CSRF_RST_TMR_CFG   8'hff
`define CSRF_RST_PA_DIR    5'h1f
`define CSRF_RST_PB_DIR    8'hff
`define CSRF_RST_ZERO8     8'h00
// Implemented-bit masks
`define CSRF_MSK_CMP_WR    4'hf
`define CSRF_MSK_VREF      8'hef
`define CSRF_MSK_RC        2'h3

`endif

// *** verification/csrf_core_sfr_assertions.sv ***
/*
  Assertions on the core register bank ports, bound to the top module.
  Assumes one clock and the active-low power-on reset.
*/
`timescale 1ns/1ps
module csrf_core_sfr_assertions (
  // Clock, reset and bus
  input logic        clk,
  input logic        rst_b,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic [31:0] prdata,
  // Reset causes and flag update
  input logic        ext_clear_rst,
  input logic        brownout_rst,
  input logic        watchdog_rst,
  input logic        flag_update,
  input logic        flag_z_in,
  input logic        flag_dc_in,
  input logic        flag_c_in,
  // Registers
  input logic [7:0]  core_flags,
  input logic [4:0]  pc_high_latch,
  input logic [4:0]  port_a_direction,
  input logic [4:0]  port_a_pins,
  input logic [7:0]  irq_control
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Any non-power-up reset
  logic any_rst;
  assign any_rst = ext_clear_rst | brownout_rst | watchdog_rst;
  ////////////////////////////////////////////////////////////////////
  // Bus answers one cycle after setup, for one cycle only
  ready_after_setup_a:
    assert property (psel && !penable |=> pready && prdata[31:8] == 0)
    else $error("no answer after setup");
  ready_single_a:
    assert property (pready |=> !pready)
    else $error("ready held too long");
  // Soft reset values; a flag update in that cycle is kept apart
  reset_values_a:
    assert property (any_rst |=> pc_high_latch == 5'h00 &&
      port_a_direction == 5'h1f)
    else $error("soft reset values wrong");
  flags_reset_a:
    assert property (any_rst && !flag_update |=> core_flags[7:5] == 0 &&
      core_flags[4] == !$past(watchdog_rst) && core_flags[3] &&
      $stable(core_flags[2:0]))
    else $error("soft reset flags wrong");
  pins_kept_a:
    assert property (any_rst |=> port_a_pins[3:0] == 4'h0 &&
      $stable(port_a_pins[4]))
    else $error("port pins not kept");
  irq_kept_a:
    assert property (any_rst |=> irq_control[7:1] == 7'h00 &&
      $stable(irq_control[0]))
    else $error("irq control not kept");
  // Timeout and power-down move only at a reset
  flag_bits_fixed_a:
    assert property (!any_rst |=> $stable(core_flags[4:3]))
    else $error("timeout or power-down moved");
  update_wins_a:
    assert property (flag_update && !any_rst |=>
      core_flags[2:0] == $past({flag_z_in, flag_dc_in, flag_c_in}))
    else $error("flag update lost");
endmodule // csrf_core_sfr_assertions

bind csrf_core_sfr csrf_core_sfr_assertions chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .ext_clear_rst(ext_clear_rst),
  .brownout_rst(brownout_rst), .watchdog_rst(watchdog_rst),
  .flag_update(flag_update), .flag_z_in(flag_z_in),
  .flag_dc_in(flag_dc_in), .flag_c_in(flag_c_in),
  .core_flags(core_flags), .pc_high_latch(pc_high_latch),
  .port_a_direction(port_a_direction), .port_a_pins(port_a_pins),
  .irq_control(irq_control)
);

// *** verification/csrf_core_model.sv ***
/*
  Core-side model: reset cause pulses and flag updates.
  Assumes each task is started just after a rising clock edge.
*/
`timescale 1ns/1ps
module csrf_core_model (
  // Clock
  input  logic clk,
  // Reset causes and comparator change
  output logic ext_clear_rst,
  output logic brownout_rst,
  output logic watchdog_rst,
  output logic cmp_change,
  // Flag update from the executed instruction
  output logic flag_update,
  output logic flag_z_in,
  output logic flag_dc_in,
  output logic flag_c_in
);
  // Idle: no pulses; flag lines carry junk while not qualified
  initial
  begin
    {cmp_change, ext_clear_rst, brownout_rst, watchdog_rst} = 4'h0;
    flag_update = 1'b0;
    {flag_z_in, flag_dc_in, flag_c_in} = 3'h5;
  end
  ////////////////////////////////////////////////////////////////////
  // One-cycle pulses: {comparator change, clear pin, brown-out, watchdog}
  task pulse(input [3:0] k);
    @(posedge clk);
    {cmp_change, ext_clear_rst, brownout_rst, watchdog_rst} <= k;
    @(posedge clk);
    {cmp_change, ext_clear_rst, brownout_rst, watchdog_rst} <= 4'h0;
  endtask
  // Inverted after the update so stale flags are never trusted
  task flags(input [2:0] f);
    @(posedge clk);
    flag_update <= 1'b1;
    {flag_z_in, flag_dc_in, flag_c_in} <= f;
    @(posedge clk);
    flag_update <= 1'b0;
    {flag_z_in, flag_dc_in, flag_c_in} <= ~f;
  endtask
endmodule // csrf_core_model

// *** verification/test_core_special_register_file.sv ***
/*
  Self-checking bench for the core register bank over APB.
  Assumes the core model drives flags and reset pulses.
*/
`timescale 1ns/1ps
module test_core_special_register_file;
  logic        clk = 1'b0, rst_b = 1'b0, bank = 1'b0, er;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, q;
  logic [1:0]  cmp = 2'b00;
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_clear_rst, brownout_rst, watchdog_rst;
  wire         cmp_change, flag_update, flag_z_in, flag_dc_in, flag_c_in;
  int          errors = 0, comparisons = 0, cyc = 0;
  // File index and expected byte: power-on set, then after a watchdog
  logic [15:0] tab [0:31] = '{16'h0318, 16'h0200, 16'h0a00, 16'h0500,
    16'h0b00, 16'h0c00, 16'h1f00, 16'h0000, 16'h0700, 16'h0d00,
    16'h81ff, 16'h851f, 16'h86ff, 16'h8c00, 16'h8e00, 16'h9f00,
    16'h8338, 16'h8d00, 16'h8000, 16'h030a, 16'h0200, 16'h0a00,
    16'h0510, 16'h015a, 16'h0b01, 16'h0c00, 16'h1f00, 16'h81ff,
    16'h851f, 16'h86ff, 16'h9f00, 16'h8e03};
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  csrf_core_model core (
    .clk(clk), .ext_clear_rst(ext_clear_rst), .brownout_rst(brownout_rst),
    .watchdog_rst(watchdog_rst), .cmp_change(cmp_change),
    .flag_update(flag_update), .flag_z_in(flag_z_in),
    .flag_dc_in(flag_dc_in), .flag_c_in(flag_c_in));
  csrf_core_sfr dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clear_rst(ext_clear_rst),
    .brownout_rst(brownout_rst), .watchdog_rst(watchdog_rst),
    .flag_update(flag_update), .flag_z_in(flag_z_in),
    .flag_dc_in(flag_dc_in), .flag_c_in(flag_c_in), .cmp_out(cmp),
    .cmp_change(cmp_change), .timer_count(), .pc_low(), .core_flags(),
    .indirect_pointer(), .port_a_pins(), .port_b_pins(), .pc_high_latch(),
    .irq_control(), .periph_irq_flags(), .comparator_control(),
    .timer_prescale_config(), .port_a_direction(), .port_b_direction(),
    .periph_irq_enables(), .power_reset_cause(), .voltage_ref_control());
  task give_verdict;
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One transfer; request held until pready is seen at an edge
  task xfer(input [31:0] a, input w, input [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bank moves clobber the low flags; reserved bank bits stay clear
  task go(input [7:0] i);
    if (i[7] !== bank)
      xfer(32'h0000_000c, 1'b1, {2'b00, i[7], 5'h00});
    bank = i[7];
  endtask
  task wr(input [7:0] i, input [7:0] d);
    go(i);
    xfer({23'h00_0000, i[6:0], 2'b00}, 1'b1, d);
    if (i[6:0] == 7'h03)
      bank = d[5];
  endtask
  task rd(input [7:0] i, input [7:0] e);
    go(i);
    xfer({23'h00_0000, i[6:0], 2'b00}, 1'b0, 8'h00);
    comparisons++;
    if ({er, q} !== {1'b0, 24'h00_0000, e})
    begin
      errors++;
      $display("wrong value reg %h expected %h seen %h", i, e, q);
    end
  endtask
  task run(input int a, input int b);
    for (int k = a; k < b; k++)
      rd(tab[k][15:8], tab[k][7:0]);
  endtask
  // Every reset clears the bank bit
  task hit(input [3:0] k);
    core.pulse(k);
    bank = 1'b0;
  endtask
  // Hang guard: transfers take a few cycles each
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    run(0, 19);
    wr(8'h8a, 8'hff);
    rd(8'h8a, 8'h1f);
    rd(8'h0a, 8'h1f);
    wr(8'h8b, 8'hff);
    rd(8'h0b, 8'hff);
    wr(8'h84, 8'h3c);
    rd(8'h04, 8'h3c);
    wr(8'h82, 8'h77);
    rd(8'h02, 8'h77);
    wr(8'h9f, 8'hff);
    rd(8'h9f, 8'hef);
    wr(8'h1f, 8'hff);
    rd(8'h1f, 8'h0f);
    // Comparator levels pass a three-stage synchroniser first
    cmp <= 2'b10;
    repeat (4) @(posedge clk);
    rd(8'h1f, 8'h8f);
    cmp <= 2'b00;
    wr(8'h8d, 8'hff);
    rd(8'h8d, 8'h00);
    wr(8'h85, 8'h00);
    wr(8'h86, 8'h00);
    wr(8'h81, 8'h00);
    wr(8'h8e, 8'h03);
    wr(8'h05, 8'h1f);
    wr(8'h01, 8'h5a);
    wr(8'h03, 8'h07);
    rd(8'h03, 8'h1f);
    core.flags(3'b010);
    rd(8'h03, 8'h1a);
    core.pulse(4'b1000);
    rd(8'h0c, 8'h40);
    hit(4'b0001);
    run(19, 32);
    hit(4'b0010);
    rd(8'h03, 8'h18);
    rd(8'h8e, 8'h02);
    hit(4'b0100);
    rd(8'h03, 8'h18);
    // A write beyond the file space is refused and must not alias
    xfer(32'h0000_0208, 1'b1, 8'h55);
    comparisons++;
    if (er !== 1'b1)
    begin
      errors++;
      $display("wrong value pslverr expected 1 seen %b", er);
    end
    rd(8'h02, 8'h00);
    give_verdict;
  end
endmodule // test_core_special_register_file
